// >>> hw/aqt_pkg.sv
// Purpose: shared constants, types and mode decode for the queue status tracker
// Assumes: one 16-bit register port, word addressed
// Notes:   converter clock is the block clock
package aqt_pkg;

    // register port
    localparam int          DATA_W        = 16;
    localparam int          ADDR_W        = 2;
    localparam logic [1:0]  ADDR_STATUS   = 2'h0;
    localparam logic [1:0]  ADDR_CTRL1    = 2'h1;
    localparam logic [1:0]  ADDR_CTRL2    = 2'h2;

    // status layout: six flags at the top, then state field, then pointer
    localparam int          FLAG_LSB      = 10;
    localparam int          QS_LSB        = 6;
    localparam int          CWP_LSB       = 0;
    localparam logic [15:0] STATUS_RESET  = 16'h0000;

    // flag vector index, bit 5 maps to status bit 15
    localparam int          F_CF1         = 5;
    localparam int          F_PF1         = 4;
    localparam int          F_CF2         = 3;
    localparam int          F_PF2         = 2;
    localparam int          F_FIRST_QUEUE_OVERRUN_FLAG        = 1;
    localparam int          F_SECOND_QUEUE_OVERRUN_FLAG        = 0;

    // control layout
    localparam int          BIT_CIE       = 15;
    localparam int          BIT_PIE       = 14;
    localparam int          MODE_LSB      = 8;
    localparam int          BIT_RESUME    = 7;
    localparam logic [15:0] CTRL1_RESET   = 16'h0000;
    localparam logic [15:0] CTRL2_RESET   = 16'h007f;

    // operating modes
    localparam logic [4:0]  MODE_DISABLED = 5'h00;
    localparam logic [4:0]  MODE_SW_SS    = 5'h01;
    localparam logic [4:0]  MODE_SW_CS    = 5'h11;
    localparam logic [4:0]  MODE_GATE_SS  = 5'h06;
    localparam logic [4:0]  MODE_GATE_CS  = 5'h16;
    localparam logic [4:0]  MODE_RSV_A    = 5'h0f;
    localparam logic [4:0]  MODE_RSV_B    = 5'h10;
    localparam logic [4:0]  MODE_RSV_C    = 5'h1f;

    // command memory
    localparam logic [5:0]  END_CHAN      = 6'h3f;
    localparam logic [5:0]  LAST_SLOT     = 6'h3f;

    // timing, in converter clock cycles
    localparam logic [1:0]  RETRIG_CYCLES = 2'd2;
    localparam logic [1:0]  PEND_CYCLES   = 2'd2;

    typedef enum logic [1:0] {
        Q1_IDLE   = 2'b00,
        Q1_ACTIVE = 2'b01,
        Q1_PAUSED = 2'b10
    } aqt_q1_state_t;

    typedef enum logic [2:0] {
        Q2_IDLE      = 3'b000,
        Q2_ACTIVE    = 3'b001,
        Q2_PAUSED    = 3'b010,
        Q2_SUSPENDED = 3'b011,
        Q2_PENDING   = 3'b100
    } aqt_q2_state_t;

    typedef struct packed {
        logic       done;
        logic [5:0] index;
        logic [5:0] chan;
        logic       pause;
    } aqt_ccw_evt_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } aqt_bus_req_t;

    function automatic logic aqt_is_sw(input logic [4:0] m);
        return (m == MODE_SW_SS) || (m == MODE_SW_CS);
    endfunction : aqt_is_sw

    function automatic logic aqt_is_gated(input logic [4:0] m, input logic first);
        return first && ((m == MODE_GATE_SS) || (m == MODE_GATE_CS));
    endfunction : aqt_is_gated

    function automatic logic aqt_is_valid(input logic [4:0] m);
        return (m != MODE_DISABLED) && (m != MODE_RSV_A) && (m != MODE_RSV_B) && (m != MODE_RSV_C);
    endfunction : aqt_is_valid

endpackage : aqt_pkg

// >>> hw/aqt_status_tracker.sv
// Purpose: flag, state and pointer tracking for a two-queue conversion scheduler
// Assumes: all inputs synchronous to i_clock; i_ccw.done pulses once per finished word
// Notes:   queue 1 preempts queue 2; gated modes exist for queue 1 only
//
// How it works
// - flags clear on written zero, ones ignored
// - state field and pointer ignore writes
// - stop mode resets whole status register
// - end at second start, end code, last slot
// - pause flag parks queue until next trigger
// - pause on final word completes, idle unless continuous
// - software modes retrigger after two cycles
// - gate closing early sets pause flag
// - gated modes ignore word pause bits
// - pause flag updates regardless of enables
// - no overrun in software trigger modes
// - trigger during execution sets overrun only
// - extra queue 1 triggers are discarded
// - second gated end sets overrun flag
// - idle when disabled, reserved or waiting
// - never both queues active together
// - paused queue waits; queue 2 may run
// - queue 1 trigger suspends running queue 2
// - queue 2 trigger under queue 1 pends
// - pending lingers few cycles before active
// - pointer holds pause word until trigger
// - pointer marks end-code word; 0 after last slot, bq2 at second start
// - done flag and enable raise request
// - resume point latched at end or mode change
`timescale 1ns/1ns
`default_nettype none

module aqt_status_tracker
    import aqt_pkg::*;
(
    // clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst_n,
    // register port
    input  wire aqt_bus_req_t  i_bus,
    output logic [DATA_W-1:0]  o_rdata,
    // converter side
    input  wire logic          i_stop,
    input  wire logic          i_trig1,
    input  wire logic          i_trig2,
    input  wire logic          i_gate1,
    input  wire aqt_ccw_evt_t  i_ccw,
    // scheduler control
    output logic               o_run_q1,
    output logic               o_run_q2,
    output logic               o_abort_q2,
    output logic               o_q2_resume_aborted,
    // requests
    output logic               o_done_req1,
    output logic               o_done_req2,
    output logic               o_pause_req1,
    output logic               o_pause_req2
);

    aqt_q1_state_t     q1_reg,      q1_next;
    aqt_q2_state_t     q2_reg,      q2_next;
    logic [5:0]        flags_reg,   flags_next;
    logic [5:0]        cwp_reg,     cwp_next;
    logic [15:0]       ctrl1_reg;
    logic [15:0]       ctrl2_reg;
    logic [15:0]       rdata_reg;
    logic [1:0]        rt_cnt_reg;
    logic [1:0]        pend_cnt_reg;
    logic              gate_prev_reg;
    logic              seen_reg;
    logic              resume_reg;

    // decode
    wire        wr_status  = i_bus.wr && (i_bus.addr == ADDR_STATUS);
    wire        wr_ctrl1   = i_bus.wr && (i_bus.addr == ADDR_CTRL1);
    wire        wr_ctrl2   = i_bus.wr && (i_bus.addr == ADDR_CTRL2);
    wire [4:0]  mode1      = ctrl1_reg[MODE_LSB +: 5];
    wire [4:0]  mode2      = ctrl2_reg[MODE_LSB +: 5];
    wire [6:0]  bq2        = ctrl2_reg[6:0];
    wire        valid1     = aqt_is_valid(mode1);
    wire        valid2     = aqt_is_valid(mode2);
    wire        sw1        = aqt_is_sw(mode1);
    wire        sw2        = aqt_is_sw(mode2);
    wire        gated1     = aqt_is_gated(mode1, 1'b1);
    wire        gcont1     = gated1 && mode1[4];
    wire        q1_act     = (q1_reg == Q1_ACTIVE);
    wire        q2_act     = (q2_reg == Q2_ACTIVE);
    wire        rt_busy    = (rt_cnt_reg != 2'd0);
    wire        gate_rise  = i_gate1 && !gate_prev_reg;
    wire        gate_fall  = !i_gate1 && gate_prev_reg;

    // queue 1 starts from idle on its trigger, or on gate opening in gated modes
    wire        start_evt1 = gated1 ? gate_rise : i_trig1;
    wire        q1_start   = valid1 && start_evt1 && (q1_reg != Q1_ACTIVE);
    wire        q1_busy    = q1_act || q1_start;

    // completed word of the running queue
    wire        evt1       = i_ccw.done && q1_act && !rt_busy;
    wire        evt2       = i_ccw.done && q2_act && !rt_busy;
    wire        evt_any    = evt1 || evt2;
    wire        is_end_ch  = (i_ccw.chan == END_CHAN);
    wire        is_last    = (i_ccw.index == LAST_SLOT);
    wire        hit_bq2    = (({1'b0, i_ccw.index} + 7'd1) == bq2);
    wire        end_of_list_code        = is_end_ch || is_last || (evt1 && hit_bq2);
    wire        pause_hit  = i_ccw.pause && !(evt1 && gated1);
    wire        evt_sw     = evt1 ? sw1 : sw2;
    wire        retrig     = evt_any && !end_of_list_code && pause_hit && evt_sw;
    wire        pause_stop = evt_any && !end_of_list_code && pause_hit && !evt_sw;
    wire        gate_early = q1_act && gated1 && gate_fall;

    // continuous software and gated modes keep running past the end
    wire        keep1      = (mode1 == MODE_SW_CS) || (gcont1 && i_gate1);
    wire        keep2      = (mode2 == MODE_SW_CS);
    wire        second_eoq = evt1 && end_of_list_code && gcont1 && seen_reg && flags_reg[F_CF1];

    // flag set and clear vectors
    logic [5:0] flag_set;
    wire  [5:0] flag_clr = wr_status ? ~i_bus.wdata[FLAG_LSB +: 6] : 6'h00;

    always_comb
    begin
        flag_set         = 6'h00;
        flag_set[F_CF1]  = evt1 && end_of_list_code && !second_eoq;
        flag_set[F_CF2]  = evt2 && end_of_list_code;
        flag_set[F_PF1]  = (evt1 && pause_hit) || gate_early;
        flag_set[F_PF2]  = evt2 && pause_hit;
        // overrun for edge or timer triggers and for a second gated end; the trigger itself is dropped
        flag_set[F_FIRST_QUEUE_OVERRUN_FLAG] = (i_trig1 && q1_act && valid1 && !sw1 && !gated1) || second_eoq;
        flag_set[F_SECOND_QUEUE_OVERRUN_FLAG] = i_trig2 && q2_act && !sw2;
    end

    // set is ORed after the clear so a same-cycle event survives
    assign flags_next = (flags_reg & ~flag_clr) | flag_set;

    // pointer moves only on completed words, never on writes
    always_comb
    begin
        cwp_next = cwp_reg;
        if (evt_any)
        begin
            if (end_of_list_code && !is_end_ch && is_last)
                cwp_next = 6'h00;
            else if (evt1 && end_of_list_code && !is_end_ch && hit_bq2)
                cwp_next = bq2[5:0];
            else
                cwp_next = i_ccw.index;
        end
    end

    always_comb
    begin
        q1_next = q1_reg;
        if (!valid1)
            q1_next = Q1_IDLE;
        else
        begin
            case (q1_reg)
                Q1_IDLE:
                    if (q1_start)
                        q1_next = Q1_ACTIVE;
                Q1_PAUSED:
                    if (q1_start)
                        q1_next = Q1_ACTIVE;
                Q1_ACTIVE:
                    if (gate_early)
                        q1_next = Q1_IDLE;
                    else if (evt1 && end_of_list_code && !keep1)
                        q1_next = Q1_IDLE;
                    else if (evt1 && pause_stop)
                        q1_next = Q1_PAUSED;
                default:
                    q1_next = Q1_IDLE;
            endcase
        end
    end

    wire pend_done = (pend_cnt_reg == 2'd0) && !q1_busy;

    always_comb
    begin
        q2_next = q2_reg;
        if (!valid2)
            q2_next = Q2_IDLE;
        else
        begin
            case (q2_reg)
                Q2_IDLE, Q2_PAUSED:
                    if (i_trig2)
                        q2_next = q1_busy ? Q2_PENDING : Q2_ACTIVE;
                Q2_ACTIVE:
                    if (q1_start)
                        q2_next = Q2_SUSPENDED;
                    else if (evt2 && end_of_list_code && !keep2)
                        q2_next = Q2_IDLE;
                    else if (evt2 && pause_stop)
                        q2_next = Q2_PAUSED;
                Q2_SUSPENDED:
                    if (!q1_busy)
                        q2_next = Q2_ACTIVE;
                Q2_PENDING:
                    if (pend_done)
                        q2_next = Q2_ACTIVE;
                default:
                    q2_next = Q2_IDLE;
            endcase
        end
    end

    // state field: queue 1 state in the high two bits; low two bits code queue 2, suspended reads as active
    function automatic logic [3:0] aqt_qs_code(input aqt_q1_state_t a, input aqt_q2_state_t b);
        logic [1:0] lo;
        lo = 2'b00;
        case (b)
            Q2_PAUSED:    lo = 2'b01;
            Q2_SUSPENDED: lo = 2'b10;
            Q2_ACTIVE:    lo = 2'b10;
            Q2_PENDING:   lo = 2'b11;
            default:      lo = 2'b00;
        endcase
        return {a, lo};
    endfunction : aqt_qs_code

    wire [15:0] status_word = {flags_reg, aqt_qs_code(q1_reg, q2_reg), cwp_reg};
    wire [15:0] rd_mux      = (i_bus.addr == ADDR_STATUS) ? status_word :
                              (i_bus.addr == ADDR_CTRL1)  ? ctrl1_reg   :
                              (i_bus.addr == ADDR_CTRL2)  ? ctrl2_reg   : 16'h0000;

    // status and sequencing; stop mode acts like a synchronous reset here
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            flags_reg <= STATUS_RESET[FLAG_LSB +: 6];
            cwp_reg   <= STATUS_RESET[CWP_LSB +: 6];
            q1_reg    <= Q1_IDLE;
            q2_reg    <= Q2_IDLE;
        end
        else if (i_stop)
        begin
            flags_reg <= STATUS_RESET[FLAG_LSB +: 6];
            cwp_reg   <= STATUS_RESET[CWP_LSB +: 6];
            q1_reg    <= Q1_IDLE;
            q2_reg    <= Q2_IDLE;
        end
        else
        begin
            flags_reg <= flags_next;
            cwp_reg   <= cwp_next;
            q1_reg    <= q1_next;
            q2_reg    <= q2_next;
        end
    end

    // counters and gate tracking
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rt_cnt_reg    <= 2'd0;
            pend_cnt_reg  <= PEND_CYCLES;
            gate_prev_reg <= 1'b0;
            seen_reg      <= 1'b0;
        end
        else if (i_stop)
        begin
            rt_cnt_reg    <= 2'd0;
            pend_cnt_reg  <= PEND_CYCLES;
            gate_prev_reg <= 1'b0;
            seen_reg      <= 1'b0;
        end
        else
        begin
            rt_cnt_reg    <= retrig ? RETRIG_CYCLES : (rt_busy ? rt_cnt_reg - 2'd1 : 2'd0);
            pend_cnt_reg  <= (q2_reg == Q2_PENDING && !q1_busy && pend_cnt_reg != 2'd0) ?
                             pend_cnt_reg - 2'd1 : ((q2_reg == Q2_PENDING && !q1_busy) ? 2'd0 : PEND_CYCLES);
            gate_prev_reg <= i_gate1;
            seen_reg      <= i_gate1 && gcont1 && (seen_reg || (evt1 && end_of_list_code));
        end
    end

    // software registers; a new queue 2 mode also latches the resume point
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl1_reg  <= CTRL1_RESET;
            ctrl2_reg  <= CTRL2_RESET;
            resume_reg <= CTRL2_RESET[BIT_RESUME];
            rdata_reg  <= 16'h0000;
        end
        else
        begin
            if (wr_ctrl1)
                ctrl1_reg <= i_bus.wdata;
            if (wr_ctrl2)
                ctrl2_reg <= i_bus.wdata;
            if ((wr_ctrl2 && i_bus.wdata[MODE_LSB +: 5] != mode2) || (evt2 && end_of_list_code))
                resume_reg <= wr_ctrl2 ? i_bus.wdata[BIT_RESUME] : ctrl2_reg[BIT_RESUME];
            rdata_reg <= i_bus.rd ? rd_mux : 16'h0000;
        end
    end

    assign o_rdata             = rdata_reg;
    assign o_run_q1            = q1_act && !rt_busy;
    assign o_run_q2            = q2_act && !rt_busy;
    assign o_abort_q2          = q2_act && q1_start;
    assign o_q2_resume_aborted = resume_reg;
    assign o_done_req1         = flags_reg[F_CF1] && ctrl1_reg[BIT_CIE];
    assign o_done_req2         = flags_reg[F_CF2] && ctrl2_reg[BIT_CIE];
    assign o_pause_req1        = flags_reg[F_PF1] && ctrl1_reg[BIT_PIE];
    assign o_pause_req2        = flags_reg[F_PF2] && ctrl2_reg[BIT_PIE];

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    AST_ONES_KEEP_FLAGS: assert property (
        (wr_status && i_bus.wdata[15:10] == 6'h3f && !i_stop) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
        else $error("writing ones lost a flag");

    AST_ZERO_CLEARS: assert property (
        (wr_status && !i_bus.wdata[15] && !i_stop && !flag_set[F_CF1]) |=> !flags_reg[F_CF1])
        else $error("zero write did not clear done flag");

    AST_POINTER_READ_ONLY: assert property (
        (wr_status && !i_ccw.done && !i_stop) |=> (cwp_reg == $past(cwp_reg)))
        else $error("pointer changed on a write");

    AST_STOP_RESETS: assert property (
        i_stop |=> (status_word == STATUS_RESET))
        else $error("stop did not reset status");

    AST_NO_SW_OVERRUN: assert property (
        (i_trig1 && q1_act && sw1 && !i_stop) |=> !$rose(flags_reg[F_FIRST_QUEUE_OVERRUN_FLAG]))
        else $error("overrun raised in software mode");

    AST_OVERRUN_SETS: assert property (
        (i_trig1 && q1_act && valid1 && !sw1 && !gated1 && !evt1 && !i_stop) |=> (flags_reg[F_FIRST_QUEUE_OVERRUN_FLAG] && q1_act))
        else $error("overrun not raised or execution disturbed");

    AST_ONE_ACTIVE: assert property (
        !(q1_act && q2_act))
        else $error("both queues active");

    AST_SUSPEND_Q2: assert property (
        (q1_start && q2_act && valid2 && !i_stop) |-> o_abort_q2 ##1 (q2_reg == Q2_SUSPENDED))
        else $error("queue 2 not suspended");

    AST_RETRIGGER_GAP: assert property (@(posedge i_clock) disable iff (!i_rst_n || i_stop)
        $rose(rt_busy) |-> (rt_busy && !o_run_q1 && !o_run_q2)[*2] ##1 !rt_busy)
        else $error("retrigger gap not two cycles");

    AST_PEND_LINGERS: assert property (
        (q2_reg == Q2_PENDING && q1_act ##1 !q1_act && !i_stop && valid2) |=> (q2_reg == Q2_PENDING))
        else $error("pending state did not linger");

    AST_PAUSE_PARKS: assert property (
        (evt1 && pause_stop && valid1 && !i_stop) |=> (q1_reg == Q1_PAUSED && flags_reg[F_PF1]))
        else $error("queue 1 did not park on pause");

    // a pause on the final word finishes the scan instead of parking it
    AST_PAUSE_AT_END: assert property (
        (evt1 && end_of_list_code && i_ccw.pause && !gated1 && mode1 != MODE_SW_CS && valid1 && !i_stop)
        |=> (q1_reg == Q1_IDLE && flags_reg[F_CF1] && flags_reg[F_PF1]))
        else $error("pause on final word did not complete");

    AST_GATED_NO_PAUSE: assert property (
        (evt1 && gated1 && i_ccw.pause && !gate_early && !i_stop) |=> !$rose(flags_reg[F_PF1]))
        else $error("pause bit raised flag in gated mode");

    COV_PREEMPT:  cover property (q2_act ##1 q2_reg == Q2_SUSPENDED ##[1:50] q2_act);
    COV_PEND:     cover property (q2_reg == Q2_PENDING ##[1:50] q2_act);
    COV_PAUSE:    cover property (q1_reg == Q1_PAUSED ##[1:50] q1_act);
    COV_GATE_TOR: cover property (second_eoq);

endmodule : aqt_status_tracker

`default_nettype wire

// >>> test/tb_top.sv
// Purpose: self-checking bench for the queue status tracker
// Assumes: register port and converter pulses are driven just after rising edges
// Notes:   the bench model keeps flags, state field and pointer as integers
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import aqt_pkg::*;
();
    logic         i_clock = 1'b0;
    logic         i_rst_n = 1'b0;
    aqt_bus_req_t bus     = '0;
    aqt_ccw_evt_t conversion_command_word     = '0;
    logic         stop    = 1'b0;
    logic         trig1   = 1'b0;
    logic         trig2   = 1'b0;
    logic         gate1   = 1'b0;
    logic [15:0]  rdata;
    logic         run1, run2, abort2, resume, dreq1, dreq2, preq1, preq2;
    logic [15:0]  d;
    int           n_fail  = 0;
    int           checks  = 0;
    int           seed    = 32;
    int           cyc     = 0;
    int           f       = 0;
    int           qs      = 0;
    int           command_word_pointer     = 0;
    int           idx;

    aqt_status_tracker u_aqt_status_tracker (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
        .i_stop(stop), .i_trig1(trig1), .i_trig2(trig2), .i_gate1(gate1), .i_ccw(conversion_command_word),
        .o_run_q1(run1), .o_run_q2(run2), .o_abort_q2(abort2), .o_q2_resume_aborted(resume),
        .o_done_req1(dreq1), .o_done_req2(dreq2), .o_pause_req1(preq1), .o_pause_req2(preq2));

    always #20 i_clock = ~i_clock;

    task automatic conclude();
        $display("counts: %0d checks, %0d mismatches", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // a hang is cut short long after the roughly 150 cycles the tests need
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            n_fail++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        checks++;
        if (seen !== want)
        begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge i_clock);
        bus <= '{1'b1, 1'b0, a, v};
        @(posedge i_clock);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [15:0] v);
        @(posedge i_clock);
        bus <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge i_clock);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    // model view of the status word: six flags, state field, pointer
    task automatic chk_st(input logic [15:0] m, input string what);
        logic [15:0] v;
        rd(ADDR_STATUS, v);
        check(v & m, {f[5:0], qs[3:0], command_word_pointer[5:0]} & m, what);
    endtask : chk_st

    task automatic word(input logic [5:0] i, input logic [5:0] ch, input logic p);
        @(posedge i_clock);
        conversion_command_word <= '{1'b1, i, ch, p};
        @(posedge i_clock);
        conversion_command_word.done <= 1'b0;
    endtask : word

    task automatic trig(input int q);
        @(posedge i_clock);
        if (q == 1) trig1 <= 1'b1;
        else trig2 <= 1'b1;
        @(posedge i_clock);
        trig1 <= 1'b0;
        trig2 <= 1'b0;
    endtask : trig

    task automatic stop_mode();
        @(posedge i_clock);
        stop <= 1'b1;
        @(posedge i_clock);
        stop <= 1'b0;
        f = 0; qs = 0; command_word_pointer = 0;
    endtask : stop_mode

    initial
    begin
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'b1;
        chk_st(16'hffff, "status reset");
        rd(ADDR_CTRL2, d);
        check(d, CTRL2_RESET, "ctrl2 reset");
        rd(2'h3, d);
        check(d, 16'h0000, "unmapped read");
        $display("test reset done");

        // software single scan, end by channel code, then flag writes
        wr(ADDR_CTRL1, {2'b11, 1'b0, MODE_SW_SS, 8'h00});
        trig(1);
        #1 check(16'(run1), 16'h0001, "sw start runs");
        idx = $random(seed) & 32'h1f;
        word(6'(idx), END_CHAN, 1'b0);
        f = 6'h20; command_word_pointer = idx; qs = 0;
        chk_st(16'hffff, "end by code");
        check(16'(dreq1), 16'h0001, "done request");
        wr(ADDR_STATUS, 16'($random(seed)) | 16'hfc00);
        chk_st(16'hffff, "ones and field writes ignored");
        wr(ADDR_STATUS, 16'h7fff);
        f = 0;
        chk_st(16'hffff, "zero clears done flag");
        check(16'(dreq1), 16'h0000, "done request drops");
        $display("test software end done");

        // software pause retriggers itself after two cycles
        trig(1);
        word(6'h03, 6'h05, 1'b1);
        #1 check(16'(run1), 16'h0000, "retrigger gap 1");
        @(posedge i_clock);
        #1 check(16'(run1), 16'h0000, "retrigger gap 2");
        @(posedge i_clock);
        #1 check(16'(run1), 16'h0001, "retrigger resumes");
        trig(1);
        f = 6'h10; qs = 4'b0100; command_word_pointer = 3;
        chk_st(16'hffc0, "pause flag, no overrun, active");
        check(16'(preq1), 16'h0001, "pause request");
        word(6'h04, END_CHAN, 1'b0);
        wr(ADDR_STATUS, 16'h0000);
        f = 0; qs = 0; command_word_pointer = 4;
        chk_st(16'hffff, "software scan closed");
        $display("test software pause done");

        // external trigger with enables off: overrun, pause, pause at end, last slot
        wr(ADDR_CTRL1, {3'b000, 5'h02, 8'h00});
        trig(1);
        trig(1);
        #1 check(16'(run1), 16'h0001, "overrun keeps running");
        word(6'h07, 6'h02, 1'b1);
        #1 check(16'(run1), 16'h0000, "paused queue idle");
        f = 6'h12; qs = 4'b1000; command_word_pointer = 7;
        chk_st(16'hffff, "overrun and paused");
        check(16'(preq1), 16'h0000, "pause request masked");
        trig(1);
        qs = 4'b0100;
        chk_st(16'h03c0, "trigger resumes");
        word(6'h08, END_CHAN, 1'b1);
        f = 6'h32; qs = 0; command_word_pointer = 8;
        chk_st(16'hffff, "pause on final word");
        trig(1);
        word(LAST_SLOT, 6'h01, 1'b0);
        command_word_pointer = 0;
        chk_st(16'hffff, "last slot ends");
        stop_mode();
        chk_st(16'hffff, "stop clears status");
        rd(ADDR_CTRL1, d);
        check(d, 16'h0200, "stop keeps control");
        $display("test external done");

        // priority: suspend, end at second start, pending linger
        wr(ADDR_CTRL2, 16'hc2a0);
        #1 check(16'(resume), 16'h0001, "resume point latched");
        trig(2);
        @(posedge i_clock);
        trig1 <= 1'b1;
        #1 check(16'(abort2), 16'h0001, "abort on preempt");
        @(posedge i_clock);
        trig1 <= 1'b0;
        #1 check(16'({run1, run2}), 16'h0002, "one queue active");
        qs = 4'b0110;
        chk_st(16'h03c0, "queue 2 suspended");
        word(6'h1f, 6'h05, 1'b0);
        repeat (4) @(posedge i_clock);
        f = 6'h20; qs = 4'b0010; command_word_pointer = 32;
        chk_st(16'hffff, "end before second start");
        wr(ADDR_CTRL2, 16'hc220);
        #1 check(16'(resume), 16'h0001, "resume change waits");
        word(6'h28, END_CHAN, 1'b0);
        f = 6'h28; qs = 0; command_word_pointer = 40;
        chk_st(16'hffff, "queue 2 done");
        check(16'(resume), 16'h0000, "resume taken at end");
        check(16'(dreq2), 16'h0001, "queue 2 done request");
        trig(1);
        trig(2);
        qs = 4'b0111;
        chk_st(16'h03c0, "queue 2 pending");
        word(6'h0a, END_CHAN, 1'b0);
        #1 check(16'(run2), 16'h0000, "linger 1");
        @(posedge i_clock);
        #1 check(16'(run2), 16'h0000, "linger 2");
        repeat (2) @(posedge i_clock);
        #1 check(16'(run2), 16'h0001, "queue 2 takes over");
        qs = 4'b0010;
        chk_st(16'h03c0, "queue 2 active");
        word(6'h21, 6'h05, 1'b1);
        f = 6'h2c; qs = 4'b0001; command_word_pointer = 33;
        chk_st(16'hffff, "queue 2 paused");
        check(16'(preq2), 16'h0001, "queue 2 pause request");
        $display("test priority done");

        // gated single: pause bit ignored, early close; gated continuous double end
        stop_mode();
        wr(ADDR_CTRL1, {3'b000, MODE_GATE_SS, 8'h00});
        @(posedge i_clock);
        gate1 <= 1'b1;
        word(6'h05, 6'h01, 1'b1);
        #1 check(16'(run1), 16'h0001, "gated ignores pause");
        qs = 4'b0100;
        chk_st(16'hfdc0, "no pause flag");
        @(posedge i_clock);
        gate1 <= 1'b0;
        repeat (2) @(posedge i_clock);
        f = 6'h10; qs = 0;
        chk_st(16'hffc0, "gate closed early");
        wr(ADDR_STATUS, 16'h0000);
        wr(ADDR_CTRL1, {3'b000, MODE_GATE_CS, 8'h00});
        @(posedge i_clock);
        gate1 <= 1'b1;
        word(6'h06, END_CHAN, 1'b0);
        word(6'h06, END_CHAN, 1'b0);
        f = 6'h22; qs = 4'b0100; command_word_pointer = 6;
        chk_st(16'hffff, "second end overruns");
        $display("test gated done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
